// file: rtl/nvm_ahb_access_controller.v
// AHB slave controller for the embedded non-volatile array read and program ports
//
// Behaviour
// RL1: Single AHB clock domain, AHB slave port.
// RL2: Program port is 32 bits wide.
// RL3: Read port is 64 bits wide.
// RL4: Array clock derived, at most 26.3 MHz.
// RL5: Pulse phases span whole cycles covering 80 ns.
// RL6: Array clock only runs on demand.
// RL7: Array clock restarts on any cycle.
// RL8: Every read miss fetches 64 bits into buffer.
// RL9: Buffer hit returns data without access.
// RL10: Program port accesses pass straight through.
// RL11: Program write waits for grant, then releases.
// RL12: Next program operation waits for grant again.
// RL13: 512-byte configuration region at 0x20200000.
// RL14: 128 KB read-only space in four sectors.
// RL15: Agent issues only whole-page operations.
// RL16: Pages 256 bytes plain, 236 authenticated.
// RL17: No processor writes to array contents.
// RL18: Miss stalls, returns half chosen by bit 2.
// RL19: Buffer invalid after reset and program writes.
`timescale 1ns/100ps
`default_nettype none
`include "nvm_ctrl_regs.vh"

module nvm_ahb_access_controller #(
    parameter HALF_CYCLES = `ARRAY_HALF_CYCLES,
    parameter PAGE_PLAIN  = `PAGE_PLAIN_BYTES,
    parameter PAGE_AUTH   = `PAGE_AUTH_BYTES
) (
    // Clock and reset
    input  wire        CLOCK_IN,
    input  wire        SYS_RST_IN,
    // AHB slave
    input  wire        HSEL_IN,
    input  wire [31:0] HADDR_IN,
    input  wire [1:0]  HTRANS_IN,
    input  wire        HWRITE_IN,
    input  wire [2:0]  HSIZE_IN,
    input  wire [31:0] HWDATA_IN,
    input  wire        HREADY_IN,
    output wire        HREADYOUT_OUT,
    output reg  [31:0] HRDATA_OUT,
    output wire        HRESP_OUT,
    // Array clock and clock request
    output reg         ARRAY_CLK_OUT,
    input  wire        ARRAY_CLK_REQ_IN,
    // Read port
    output reg         R_REQ_OUT,
    output reg  [16:3] R_ADDR_OUT,
    input  wire        R_ACK_IN,
    input  wire [63:0] R_DATA_IN,
    // Program / configuration port
    output reg         C_REQ_OUT,
    output reg         C_WRITE_OUT,
    output reg  [8:2]  C_ADDR_OUT,
    output reg  [31:0] C_WDATA_OUT,
    input  wire        C_GRANT_IN,
    input  wire [31:0] C_RDATA_IN,
    // Page sizes for the programming agent
    output wire [8:0]  PAGE_PLAIN_BYTES_OUT,
    output wire [8:0]  PAGE_AUTH_BYTES_OUT
);

    // ****************************************
    // States
    // ****************************************
    localparam ST_IDLE   = 3'h0;
    localparam ST_RFETCH = 3'h1;
    localparam ST_CWAIT  = 3'h2;
    localparam ST_CREAD  = 3'h3;
    localparam ST_ERR1   = 3'h4;
    localparam ST_ERR2   = 3'h5;
    localparam ST_CPEND  = 3'h6;
    // Program read data stands here; behaves as idle for a new request
    localparam ST_CDONE  = 3'h7;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [15:0] half_cnt;
    reg  [63:0] buf_data;
    reg  [16:3] buf_addr;
    reg         buf_valid;
    reg         rd_sel_hi;
    reg         cw_pending;
    reg  [8:2]  cw_addr;

    // ****************************************
    // Address decode
    // ****************************************
    wire        start   = HSEL_IN & HREADY_IN & HTRANS_IN[1];      // [RL1]
    wire        in_cfg  = (HADDR_IN >= `CFG_BASE) &&
                          (HADDR_IN < (`CFG_BASE + `CFG_SIZE));   // [RL13]
    wire        in_read = (HADDR_IN >= `READ_BASE) &&
                          (HADDR_IN < (`READ_BASE + `READ_SIZE)); // [RL14]
    wire [31:0] roff    = HADDR_IN - `READ_BASE;
    wire        hit     = buf_valid && (buf_addr == roff[16:3]);  // [RL9]

    // Sector index, kept for debug visibility of the four-sector map
    wire [1:0]  sector  = (roff < `SECTOR_B_OFFSET) ? 2'h0 :
                          (roff < `SECTOR_C_OFFSET) ? 2'h1 :
                          (roff < `SECTOR_D_OFFSET) ? 2'h2 : 2'h3; // [RL14]

    assign PAGE_PLAIN_BYTES_OUT = PAGE_PLAIN[8:0]; // [RL16]
    assign PAGE_AUTH_BYTES_OUT  = PAGE_AUTH[8:0];  // [RL16]

    // ****************************************
    // Array clock: gated divider, restartable
    // ****************************************
    // Starts only while a read fetch is pending or the array asks; a high phase already begun runs to its end
    wire clk_need = R_REQ_OUT | ARRAY_CLK_REQ_IN;              // [RL6]
    wire phase_end = (half_cnt == (HALF_CYCLES[15:0] - 16'h0001));

    // Each phase lasts HALF_CYCLES clocks, so period >= 2*80 ns
    always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            ARRAY_CLK_OUT <= 1'b0;
            half_cnt      <= 16'h0000;
        end else if (!clk_need && !ARRAY_CLK_OUT) begin
            half_cnt      <= 16'h0000;                          // [RL6]
        end else if (phase_end) begin
            ARRAY_CLK_OUT <= ~ARRAY_CLK_OUT;                    // [RL4] [RL5]
            half_cnt      <= 16'h0000;
        end else begin
            half_cnt      <= half_cnt + 16'h0001;               // [RL7]
        end
    end

    // Read data is taken on the last cycle of a high phase, as the array clock falls
    wire array_edge = phase_end && ARRAY_CLK_OUT;

    // ****************************************
    // Next state
    // ****************************************
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE, ST_CDONE: begin
                next_state = ST_IDLE;
                if (start) begin
                    if (in_read && !HWRITE_IN && !hit)
                        next_state = ST_RFETCH;                 // [RL18]
                    else if (in_read && HWRITE_IN)
                        next_state = ST_ERR1;                   // [RL17]
                    else if (in_cfg && HWRITE_IN)
                        next_state = ST_CPEND;
                    else if (in_cfg)
                        next_state = ST_CREAD;
                    else if (!in_read)
                        next_state = ST_ERR1;
                end
            end
            ST_RFETCH: if (R_ACK_IN && array_edge) next_state = ST_IDLE;
            ST_CPEND:  next_state = ST_CWAIT;
            ST_CWAIT:  if (C_GRANT_IN) next_state = ST_IDLE;    // [RL11]
            ST_CREAD:  if (C_GRANT_IN) next_state = ST_CDONE;   // [RL12]
            ST_ERR1:   next_state = ST_ERR2;
            ST_ERR2:   next_state = ST_IDLE;
            default:   next_state = ST_IDLE;
        endcase
    end

    // ****************************************
    // AHB response
    // ****************************************
    // Write data phase waits for grant; reads wait until data is registered
    assign HREADYOUT_OUT = (state == ST_IDLE) || (state == ST_ERR2) ||
                           ((state == ST_CWAIT) && C_GRANT_IN) ||
                           (state == ST_CDONE);                 // [RL11]
    assign HRESP_OUT = ((state == ST_ERR1) || (state == ST_ERR2)) ?
                       `HRESP_ERROR : `HRESP_OKAY;              // [RL17]

    // ****************************************
    // Sequential control and datapath
    // ****************************************
    always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state       <= ST_IDLE;
            buf_valid   <= 1'b0;                                // [RL19]
            buf_data    <= 64'h0000000000000000;
            buf_addr    <= 14'h0000;
            rd_sel_hi   <= 1'b0;
            R_REQ_OUT   <= 1'b0;
            R_ADDR_OUT  <= 14'h0000;
            C_REQ_OUT   <= 1'b0;
            C_WRITE_OUT <= 1'b0;
            C_ADDR_OUT  <= 7'h00;
            C_WDATA_OUT <= 32'h00000000;
            HRDATA_OUT  <= 32'h00000000;
            cw_pending  <= 1'b0;
            cw_addr     <= 7'h00;
        end else begin
            state <= next_state;
            case (state)
                ST_IDLE, ST_CDONE: begin
                    if (start && in_read && !HWRITE_IN) begin
                        if (hit) begin
                            // Hit: answer from buffer, no array access
                            HRDATA_OUT <= roff[2] ? buf_data[63:32]
                                                  : buf_data[31:0]; // [RL9]
                        end else begin
                            R_REQ_OUT  <= 1'b1;                 // [RL8] [RL3]
                            R_ADDR_OUT <= roff[16:3];
                            rd_sel_hi  <= roff[2];
                        end
                    end else if (start && in_cfg) begin
                        // Address now, write data follows next cycle
                        cw_addr    <= HADDR_IN[8:2];            // [RL10]
                        cw_pending <= HWRITE_IN;
                        if (!HWRITE_IN) begin
                            C_REQ_OUT   <= 1'b1;                // [RL10]
                            C_WRITE_OUT <= 1'b0;
                            C_ADDR_OUT  <= HADDR_IN[8:2];
                        end
                    end
                end
                ST_CPEND: begin
                    C_REQ_OUT   <= 1'b1;                        // [RL2]
                    C_WRITE_OUT <= 1'b1;
                    C_ADDR_OUT  <= cw_addr;
                    C_WDATA_OUT <= HWDATA_IN;
                    buf_valid   <= 1'b0;                        // [RL19]
                end
                ST_RFETCH: begin
                    if (R_ACK_IN && array_edge) begin
                        R_REQ_OUT  <= 1'b0;
                        buf_data   <= R_DATA_IN;                // [RL8]
                        buf_addr   <= R_ADDR_OUT;
                        buf_valid  <= 1'b1;
                        HRDATA_OUT <= rd_sel_hi ? R_DATA_IN[63:32]
                                                : R_DATA_IN[31:0]; // [RL18]
                    end
                end
                ST_CWAIT: begin
                    if (C_GRANT_IN) begin
                        C_REQ_OUT  <= 1'b0;                     // [RL11]
                        cw_pending <= 1'b0;
                    end
                end
                ST_CREAD: begin
                    if (C_GRANT_IN) begin
                        C_REQ_OUT  <= 1'b0;
                        HRDATA_OUT <= C_RDATA_IN;               // [RL10]
                    end
                end
                default: begin
                    R_REQ_OUT <= R_REQ_OUT;
                end
            endcase
        end
    end

endmodule // nvm_ahb_access_controller

`default_nettype wire

// file: rtl/nvm_ctrl_regs.vh
// Constants for the non-volatile array access controller
`ifndef NVM_CTRL_REGS_VH
`define NVM_CTRL_REGS_VH

// ****************************************
// Address map
// ****************************************
`define CFG_BASE          32'h20200000
`define CFG_SIZE          32'h00000200
`define READ_BASE         32'h20220000
`define READ_SIZE         32'h00020000
`define SECTOR_A_OFFSET   32'h00000000
`define SECTOR_B_OFFSET   32'h00002000
`define SECTOR_C_OFFSET   32'h00010000
`define SECTOR_D_OFFSET   32'h0001E000

// ****************************************
// Page sizes in bytes
// ****************************************
`define PAGE_PLAIN_BYTES  256
`define PAGE_AUTH_BYTES   236

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS     50
`define ARRAY_ACCESS_NS   80
`define ARRAY_FMAX_KHZ    26300
// Half period of array clock in AHB cycles: ceil(80 / 50)
`define ARRAY_HALF_CYCLES ((`ARRAY_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************
// AHB encodings
// ****************************************
`define HTRANS_NONSEQ     2'h2
`define HRESP_OKAY        1'h0
`define HRESP_ERROR       1'h1

`endif

// file: verification/nvm_ahb_access_controller_asserts.sv
// Port checker for the array access controller
`timescale 1ns/100ps
`default_nettype none
// ****
// Checker
// ****
module nvm_ctrl_chk #(parameter HALF_CYCLES = 2) (
    // Clock, reset and AHB
    input wire        CLOCK_IN, SYS_RST_IN, HSEL_IN, HREADY_IN, HWRITE_IN,
    input wire [1:0]  HTRANS_IN,
    input wire [31:0] HADDR_IN,
    input wire        HREADYOUT_OUT, HRESP_OUT,
    // Array side
    input wire        ARRAY_CLK_OUT, ARRAY_CLK_REQ_IN, R_REQ_OUT, C_REQ_OUT, C_GRANT_IN,
    input wire        C_WRITE_OUT,
    input wire [16:3] R_ADDR_OUT,
    input wire [8:0]  PAGE_PLAIN_BYTES_OUT, PAGE_AUTH_BYTES_OUT
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // Address phase accepted by an idle slave
    wire take = HSEL_IN && HREADY_IN && HTRANS_IN[1] && HREADYOUT_OUT;
    AST_PAGE: assert property (PAGE_PLAIN_BYTES_OUT == 9'h100 && PAGE_AUTH_BYTES_OUT == 9'h0EC)
        else $error("page size outputs wrong");
    AST_HIGH: assert property ($rose(ARRAY_CLK_OUT) |-> ARRAY_CLK_OUT[*2] ##1 !ARRAY_CLK_OUT)
        else $error("array clock high phase wrong");
    AST_LOW: assert property ($fell(ARRAY_CLK_OUT) |-> !ARRAY_CLK_OUT[*2])
        else $error("array clock low phase too short");
    // Gated clock must not wake without a need
    AST_IDLE: assert property ((!ARRAY_CLK_OUT && !R_REQ_OUT && !ARRAY_CLK_REQ_IN) ##1
        (!R_REQ_OUT && !ARRAY_CLK_REQ_IN) |-> !ARRAY_CLK_OUT) else $error("array clock ran idle");
    AST_WRRO: assert property (take && HWRITE_IN && HADDR_IN[31:17] == 15'h1011 |=>
        HRESP_OUT && !HREADYOUT_OUT ##1 HRESP_OUT && HREADYOUT_OUT) else $error("read space write");
    AST_WAIT: assert property (C_REQ_OUT && !C_GRANT_IN |-> !HREADYOUT_OUT)
        else $error("program port released before grant");
    AST_FREE: assert property (C_REQ_OUT && C_WRITE_OUT && C_GRANT_IN |-> HREADYOUT_OUT)
        else $error("program port not released on grant");
    AST_CREAD: assert property (C_REQ_OUT && !C_WRITE_OUT && C_GRANT_IN |=> HREADYOUT_OUT)
        else $error("program read not answered after grant");
    AST_FETCH: assert property (R_REQ_OUT |-> !HREADYOUT_OUT)
        else $error("ready during fetch");
    AST_RHOLD: assert property (R_REQ_OUT && !ARRAY_CLK_OUT |=> R_REQ_OUT && $stable(R_ADDR_OUT))
        else $error("fetch dropped before answer");
endmodule // nvm_ctrl_chk
bind nvm_ahb_access_controller nvm_ctrl_chk #(.HALF_CYCLES(HALF_CYCLES)) i_chk (.*);
`default_nettype wire

// file: verification/nvm_array_model.sv
// Behavioural model of the array read and program ports
`timescale 1ns/100ps
`default_nettype none
// ****
// Array model
// ****
module nvm_array_model (
    // Controls
    input  wire         clk_in, rst_in, array_clk_in, r_req_in, c_req_in, c_write_in,
    input  wire  [16:3] r_addr_in,
    input  wire  [8:2]  c_addr_in,
    input  wire  [31:0] c_wdata_in,
    input  wire  [3:0]  grant_wait_in,
    // Answers
    output logic        r_ack_out, c_grant_out,
    output logic [63:0] r_data_out,
    output logic [31:0] c_rdata_out
);
    logic [31:0] cfg [0:127];
    logic [3:0]  cnt;
    wire  [63:0] word = {18'h0002A, r_addr_in, 18'h00015, r_addr_in};
    // Answer only in a high phase; idle bus shows the inverse so stale data is caught
    assign r_ack_out = r_req_in && array_clk_in;
    assign r_data_out = r_ack_out ? word : ~word;
    // Grant after a set wait, then dropped so each operation needs a fresh one
    assign c_grant_out = c_req_in && cnt >= grant_wait_in;
    assign c_rdata_out = c_grant_out ? cfg[c_addr_in] : ~cfg[c_addr_in];
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            cnt <= 4'h0;
        else
            cnt <= (c_grant_out || !c_req_in) ? 4'h0 : cnt + 4'h1;
    end
    // Program writes land on grant; the agent sends whole pages only
    always @(posedge clk_in) begin
        if (c_grant_out && c_write_in)
            cfg[c_addr_in] <= c_wdata_in;
    end
endmodule // nvm_array_model
`default_nettype wire

// file: verification/nvm_ahb_access_controller_tb_top.sv
// Self-checking testbench for the array access controller
`timescale 1ns/100ps
`default_nettype none
// ****
// Bench
// ****
module nvm_ahb_access_controller_tb_top;
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, clk_req = 1'b0, rsp;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [31:0] offs [0:3] = '{32'h0, 32'h2000, 32'h10000, 32'h1E000};
    logic [3:0]  gw = 4'h2;
    integer      err_count = 0, tests_run = 0, n, i, k;
    wire         hready, hresp, aclk, rreq, rack, creq, cwr, cgnt;
    wire  [31:0] hrdata, cwd, crd;
    wire  [16:3] raddr;
    wire  [8:2]  caddr;
    wire  [63:0] rdata;
    nvm_ahb_access_controller i_dut (.CLOCK_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
        .HWDATA_IN(hwdata), .HREADY_IN(hready), .HREADYOUT_OUT(hready), .HRDATA_OUT(hrdata),
        .HRESP_OUT(hresp), .ARRAY_CLK_OUT(aclk), .ARRAY_CLK_REQ_IN(clk_req), .R_REQ_OUT(rreq),
        .R_ADDR_OUT(raddr), .R_ACK_IN(rack), .R_DATA_IN(rdata), .C_REQ_OUT(creq),
        .C_WRITE_OUT(cwr), .C_ADDR_OUT(caddr), .C_WDATA_OUT(cwd), .C_GRANT_IN(cgnt),
        .C_RDATA_IN(crd), .PAGE_PLAIN_BYTES_OUT(), .PAGE_AUTH_BYTES_OUT());
    nvm_array_model i_mem (.clk_in(clk), .rst_in(rst), .array_clk_in(aclk), .r_req_in(rreq),
        .c_req_in(creq), .c_write_in(cwr), .r_addr_in(raddr), .c_addr_in(caddr),
        .c_wdata_in(cwd), .grant_wait_in(gw), .r_ack_out(rack), .c_grant_out(cgnt),
        .r_data_out(rdata), .c_rdata_out(crd));
    // 20 MHz clock
    always #25 clk = ~clk;
    function automatic [31:0] half(input [31:0] a);
        half = a[2] ? {18'h0002A, a[16:3]} : {18'h00015, a[16:3]};
    endfunction
    task chk(input string nm, input [31:0] e, input [31:0] g);
        tests_run++;
        if (e !== g) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    // One AHB transfer; data phase idles the bus so read data is not reloaded
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        n = 0;
        @(negedge clk);
        while (hready !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300)
            chk("ready in time", 0, 1);
        rsp = hresp;
        @(negedge clk);
        rd = hrdata;
    endtask
    task t_read;
        for (i = 0; i < 4; i++) begin
            xfer(1'b0, 32'h20220004 + offs[i], 32'h0);
            chk("miss data", half(32'h20220004 + offs[i]), rd);
            chk("miss waits", 1, n >= 3);
            xfer(1'b0, 32'h20220000 + offs[i], 32'h0);
            chk("hit data", half(32'h20220000 + offs[i]), rd);
            chk("hit waits", 0, n);
        end
        $display("read test done");
    endtask
    task t_cfg;
        @(posedge clk);
        gw <= 4'h5;
        xfer(1'b1, 32'h20200010, 32'hC0DE0011);
        chk("write waits", 1, n >= 5);
        xfer(1'b1, 32'h202001FC, 32'h5A5A00FF);
        chk("second write waits", 1, n >= 5);
        xfer(1'b0, 32'h20200010, 32'h0);
        chk("config read", 32'hC0DE0011, rd);
        xfer(1'b0, 32'h202001FC, 32'h0);
        chk("config top", 32'h5A5A00FF, rd);
        xfer(1'b0, 32'h2023E000, 32'h0);
        chk("refetch", 1, n >= 3);
        $display("config test done");
    endtask
    task t_err;
        xfer(1'b1, 32'h20222000, 32'h1);
        chk("read space write", 1, rsp);
        xfer(1'b0, 32'h20200200, 32'h0);
        chk("past config", 1, rsp);
        xfer(1'b0, 32'h20240000, 32'h0);
        chk("past read space", 1, rsp);
        xfer(1'b0, 32'h2023FFFC, 32'h0);
        chk("last word", half(32'h2023FFFC), rd);
        $display("error test done");
    endtask
    // Clock only on request, half duty at two cycles a phase
    task t_clk;
        @(posedge clk);
        clk_req <= 1'b1;
        k = 0;
        repeat (40) begin
            @(negedge clk);
            k += aclk;
        end
        chk("clock on request", 1, k >= 18 && k <= 20);
        @(posedge clk);
        clk_req <= 1'b0;
        repeat (8) @(negedge clk);
        k = 0;
        repeat (20) begin
            @(negedge clk);
            k += aclk;
        end
        chk("idle clock", 0, k);
        $display("clock test done");
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("reset outputs", 4'h8, {hready, aclk, rreq, creq});
        t_read;
        t_cfg;
        t_err;
        t_clk;
        print_verdict;
    end
    // Tests need under a thousand cycles; four thousand means a hang
    initial begin
        #200000;
        err_count++;
        print_verdict;
    end
endmodule // nvm_ahb_access_controller_tb_top
`default_nettype wire
